// *** core/mrc_pkg.sv ***
package mrc_pkg;

   // register port geometry
   localparam int unsigned DATA_W = 32;            // register word width
   localparam int unsigned ADDR_W = 8;             // byte address width

   // byte offsets of the two control words
   localparam logic [7:0] MOTION_TARGET_OFS    = 8'h00;
   localparam logic [7:0] STARTUP_OVERRIDE_OFS = 8'h04;

   // reset values of both words
   localparam logic [31:0] MOTION_TARGET_RST    = 32'h0000_0000;
   localparam logic [31:0] STARTUP_OVERRIDE_RST = 32'h0000_0000;

   // writable bits; everything else reads as zero
   localparam logic [31:0] MOTION_TARGET_MASK    = 32'h0000_7fff;
   localparam logic [31:0] STARTUP_OVERRIDE_MASK = 32'h7fc0_ffff;

   // motion target field
   localparam int unsigned TARGET_LSB = 0;         // low bit of target
   localparam int unsigned TARGET_W   = 15;        // target width

   // startup override word field positions
   localparam int unsigned FAULT_CLR_BIT   = 31;   // self-clearing command
   localparam int unsigned ANGLE_LSB       = 22;   // forced angle low bit
   localparam int unsigned ANGLE_W         = 9;    // forced angle width
   localparam int unsigned OPEN_LOOP_BIT   = 15;   // open loop select
   localparam int unsigned HOLD_ALIGN_BIT  = 14;   // hold in align
   localparam int unsigned HOLD_SLOW_BIT   = 13;   // hold in slow cycle
   localparam int unsigned HOLD_POS_BIT    = 12;   // hold in position detect
   localparam int unsigned HOLD_SPEED_BIT  = 11;   // hold in speed detect
   localparam int unsigned ANGLE_SRC_BIT   = 10;   // rotor angle source
   localparam int unsigned IQ_LSB          = 0;    // torque code low bit
   localparam int unsigned IQ_W            = 10;   // torque code width

   // numeric constants of the angle and torque codes
   localparam logic [8:0] ANGLE_WRAP    = 9'h168;  // 360 degrees
   localparam logic [9:0] IQ_ZERO_CODE  = 10'h200; // 512, sign boundary
   localparam logic [9:0] IQ_MAX_CODE   = 10'h3e8; // 1000, last valid code

   // startup method chosen by the surrounding controller
   typedef enum logic [2:0] {
      start_align,
      start_double_align,
      start_slow_first,
      start_position_detect,
      start_other
   } mrc_startup_t;

   // one register access request
   typedef struct packed {
      logic              wr;                       // write strobe
      logic              rd;                       // read strobe
      logic [7:0]        addr;                     // byte address
      logic [31:0]       wdata;                    // write data
   } mrc_bus_req_t;

   // sequencer hold requests
   typedef struct packed {
      logic align;                                 // stay in align
      logic slow_first;                            // stay in slow cycle
      logic position_detect;                       // stay in position detect
      logic speed_detect;                          // stay in speed detect
   } mrc_hold_t;

endpackage

// *** core/mrc_angle_wrap.sv ***
`timescale 1ns/1ps
module mrc_angle_wrap
   import mrc_pkg::*;
(
   // angle in degrees, 0 to 511
   input  logic [8:0] angle_in,
   // angle folded into 0 to 359
   output logic [8:0] angle_out
);

   // one subtraction suffices: the input never reaches 720
   always_comb begin
      if (angle_in >= ANGLE_WRAP) begin
         angle_out = angle_in - ANGLE_WRAP;
      end else begin
         angle_out = angle_in;
      end
   end

endmodule // mrc_angle_wrap

// *** core/mrc_torque_decode.sv ***
`timescale 1ns/1ps
module mrc_torque_decode
   import mrc_pkg::*;
(
   // raw 10-bit torque current code
   input  logic        [9:0]  code,
   // signed counts, 511 counts stand for 10 per unit
   output logic signed [10:0] value,
   // code above the last valid one
   output logic               invalid
);

   // low half is positive, upper half is the negated offset from 512
   always_comb begin
      if (code < IQ_ZERO_CODE) begin
         value = $signed({1'b0, code});
      end else begin
         value = -$signed({2'b00, code[8:0]});
      end
      invalid = (code > IQ_MAX_CODE);
   end

endmodule // mrc_torque_decode

// *** core/mrc_realtime_regs.sv ***
`timescale 1ns/1ps
// How it works
// - 15-bit speed target, upper bits read zero
// - fault clear bit pulses, then self-clears
// - forced align angle applied modulo 360 degrees
// - open loop select bit drives open commutation
// - hold bit keeps sequencer in align state
// - hold bit keeps sequencer in slow cycle
// - hold bit keeps sequencer in position detect
// - hold bit keeps sequencer in speed detect
// - source bit picks preset or register angle
// - signed torque reference while velocity loop off
module mrc_realtime_regs
   import mrc_pkg::*;
(
   // clock and reset
   input  logic                clock,
   input  logic                nrst,
   // register access
   input  mrc_bus_req_t        bus_req,
   output logic [31:0]         rdata_ff,
   output logic                rvalid_ff,
   output logic                addr_err_ff,
   // controller context
   input  mrc_startup_t        startup_method,
   input  logic                speed_detect_enable,
   input  logic                velocity_loop_off,
   input  logic [8:0]          preset_align_angle,
   // controls toward the motor control core
   output logic [14:0]         motion_target_ff,
   output logic                fault_clear_ff,
   output logic [8:0]          align_angle_ff,
   output logic                open_loop_select_ff,
   output mrc_hold_t           hold_ff,
   output logic signed [10:0]  torque_current_reference_ff,
   output logic                torque_override_active_ff,
   output logic                torque_code_invalid_ff
);

   // stored register contents
   logic [31:0]        target_reg_ff;      // motion target word
   logic [31:0]        ctrl_reg_ff;        // startup override word

   // address decode of the current request
   logic               hit_target;         // address is motion target
   logic               hit_ctrl;           // address is override word
   logic               fault_wr;           // write carrying fault clear

   // derived combinational values
   logic [8:0]         angle_sel;          // angle before folding
   logic [8:0]         angle_wrapped;      // angle after folding
   logic signed [10:0] torque_value;       // decoded torque code
   logic               torque_invalid;     // code out of range
   logic               method_align;       // align or double align
   logic [31:0]        nxt_rdata;          // read mux result

   // full address compare, so aliases never hit
   assign hit_target = (bus_req.addr == MOTION_TARGET_OFS);
   assign hit_ctrl   = (bus_req.addr == STARTUP_OVERRIDE_OFS);
   assign fault_wr   = bus_req.wr && hit_ctrl
                       && bus_req.wdata[FAULT_CLR_BIT];

   // motion target storage; reserved bits masked off
   always_ff @(posedge clock) begin
      if (!nrst) begin
         target_reg_ff <= MOTION_TARGET_RST;
      end else if (bus_req.wr && hit_target) begin
         target_reg_ff <= bus_req.wdata & MOTION_TARGET_MASK;
      end
   end

   // override word storage; the fault clear bit is never kept
   always_ff @(posedge clock) begin
      if (!nrst) begin
         ctrl_reg_ff <= STARTUP_OVERRIDE_RST;
      end else if (bus_req.wr && hit_ctrl) begin
         ctrl_reg_ff <= bus_req.wdata & STARTUP_OVERRIDE_MASK;
      end
   end

   // fault clear command: one pulse per write, the bit reads back zero
   always_ff @(posedge clock) begin
      if (!nrst) begin
         fault_clear_ff <= 1'b0;
      end else begin
         fault_clear_ff <= fault_wr;
      end
   end

   // read mux; unmapped addresses return zero
   always_comb begin
      nxt_rdata = 32'h0000_0000;
      if (hit_target) begin
         nxt_rdata = target_reg_ff;
      end else if (hit_ctrl) begin
         nxt_rdata = ctrl_reg_ff;
      end
   end

   // read answer one cycle after the strobe
   always_ff @(posedge clock) begin
      if (!nrst) begin
         rdata_ff  <= 32'h0000_0000;
         rvalid_ff <= 1'b0;
      end else begin
         rvalid_ff <= bus_req.rd;
         if (bus_req.rd) begin
            rdata_ff <= nxt_rdata;
         end
      end
   end

   // flag any access that hits neither word
   always_ff @(posedge clock) begin
      if (!nrst) begin
         addr_err_ff <= 1'b0;
      end else begin
         addr_err_ff <= (bus_req.rd || bus_req.wr)
                        && !hit_target && !hit_ctrl;
      end
   end

   // speed or torque target, a fraction of full scale times 32768
   always_ff @(posedge clock) begin
      if (!nrst) begin
         motion_target_ff <= 15'h0000;
      end else begin
         motion_target_ff <= target_reg_ff[TARGET_LSB +: TARGET_W];
      end
   end

   // angle source: preset setting or the register field
   always_comb begin
      if (ctrl_reg_ff[ANGLE_SRC_BIT]) begin
         angle_sel = ctrl_reg_ff[ANGLE_LSB +: ANGLE_W];
      end else begin
         angle_sel = preset_align_angle;
      end
   end

   // fold into one turn; a preset angle is folded the same way
   mrc_angle_wrap u_angle_wrap (
      .angle_in  (angle_sel),
      .angle_out (angle_wrapped)
   );

   // applied align angle, always below 360
   always_ff @(posedge clock) begin
      if (!nrst) begin
         align_angle_ff <= 9'h000;
      end else begin
         align_angle_ff <= angle_wrapped;
      end
   end

   // open loop commutation select
   always_ff @(posedge clock) begin
      if (!nrst) begin
         open_loop_select_ff <= 1'b0;
      end else begin
         open_loop_select_ff <= ctrl_reg_ff[OPEN_LOOP_BIT];
      end
   end

   // the align, slow cycle and position detect holds only matter for their own startup method
   assign method_align = (startup_method == start_align)
                         || (startup_method == start_double_align);

   // sequencer holds; clearing the bit releases the state next cycle
   always_ff @(posedge clock) begin
      if (!nrst) begin
         hold_ff <= '0;
      end else begin
         hold_ff.align <= ctrl_reg_ff[HOLD_ALIGN_BIT]
                          && method_align;
         hold_ff.slow_first <= ctrl_reg_ff[HOLD_SLOW_BIT]
                          && (startup_method == start_slow_first);
         hold_ff.position_detect <= ctrl_reg_ff[HOLD_POS_BIT]
                          && (startup_method == start_position_detect);
         hold_ff.speed_detect <= ctrl_reg_ff[HOLD_SPEED_BIT]
                          && speed_detect_enable;
      end
   end

   // decode the signed torque current code
   mrc_torque_decode u_torque_decode (
      .code    (ctrl_reg_ff[IQ_LSB +: IQ_W]),
      .value   (torque_value),
      .invalid (torque_invalid)
   );

   // torque reference only while the velocity loop is off, else zero
   // out-of-range codes still pass; the flag lets software spot them
   always_ff @(posedge clock) begin
      if (!nrst) begin
         torque_current_reference_ff <= 11'sh000;
         torque_override_active_ff   <= 1'b0;
         torque_code_invalid_ff      <= 1'b0;
      end else begin
         torque_override_active_ff <= velocity_loop_off;
         torque_code_invalid_ff    <= velocity_loop_off && torque_invalid;
         if (velocity_loop_off) begin
            torque_current_reference_ff <= torque_value;
         end else begin
            torque_current_reference_ff <= 11'sh000;
         end
      end
   end

   // checks of the behaviour above
   default clocking cb @(posedge clock); endclocking
   default disable iff (!nrst);

   // a write to the override word with the fault bit set
   sequence s_fault_write;
      fault_wr;
   endsequence

   // a write to the override word that sets open loop
   sequence s_open_loop_write;
      bus_req.wr && hit_ctrl && bus_req.wdata[OPEN_LOOP_BIT];
   endsequence

   // no further write to the override word
   sequence s_ctrl_quiet;
      !(bus_req.wr && hit_ctrl);
   endsequence

   a_fault_pulse_set:
   assert property (s_fault_write |=> fault_clear_ff)
      else $error("fault clear did not pulse");

   a_fault_self_clear:
   assert property ((fault_clear_ff && !fault_wr) |=> !fault_clear_ff)
      else $error("fault clear did not return to zero");

   a_target_read_back:
   assert property ((bus_req.rd && hit_target && !bus_req.wr) |=>
      (rvalid_ff && rdata_ff[31:15] == 17'h0_0000
       && rdata_ff[14:0] == $past(target_reg_ff[14:0])))
      else $error("motion target read back wrong");

   a_reserved_read_zero:
   assert property (rvalid_ff |->
      (rdata_ff[31] == 1'b0 && rdata_ff[21:16] == 6'h00))
      else $error("reserved bits read nonzero");

   a_angle_in_range:
   assert property (align_angle_ff < ANGLE_WRAP)
      else $error("align angle not below 360");

   a_angle_field_pick:
   assert property ((ctrl_reg_ff[ANGLE_SRC_BIT]
      && ctrl_reg_ff[ANGLE_LSB +: ANGLE_W] >= ANGLE_WRAP) |=>
      (align_angle_ff + ANGLE_WRAP == $past(ctrl_reg_ff[30:22])))
      else $error("register angle not folded by 360");

   a_angle_preset_pick:
   assert property ((!ctrl_reg_ff[ANGLE_SRC_BIT]
      && preset_align_angle < ANGLE_WRAP) |=>
      (align_angle_ff == $past(preset_align_angle)))
      else $error("preset angle not selected");

   a_open_loop_follow:
   assert property ((s_open_loop_write ##1 s_ctrl_quiet) |=>
      open_loop_select_ff)
      else $error("open loop select did not follow write");

   a_hold_align_gate:
   assert property ((ctrl_reg_ff[HOLD_ALIGN_BIT] && method_align) |=>
      hold_ff.align)
      else $error("align hold not raised");

   a_hold_method_only:
   assert property ((startup_method != start_slow_first) |=>
      !hold_ff.slow_first)
      else $error("slow cycle hold under wrong method");

   a_hold_release:
   assert property (!ctrl_reg_ff[HOLD_POS_BIT] |=> !hold_ff.position_detect)
      else $error("position detect hold not released");

   a_hold_speed_gate:
   assert property ((ctrl_reg_ff[HOLD_SPEED_BIT] && speed_detect_enable)
      |=> hold_ff.speed_detect)
      else $error("speed detect hold not raised");

   a_torque_negative:
   assert property ((velocity_loop_off
      && ctrl_reg_ff[9:0] > IQ_ZERO_CODE) |=>
      (torque_current_reference_ff + $signed({1'b0, $past(ctrl_reg_ff[9:0])})
       == 11'sh200))
      else $error("negative torque code decoded wrong");

   a_torque_idle_zero:
   assert property (!velocity_loop_off |=>
      (torque_current_reference_ff == 11'sh000
       && !torque_override_active_ff))
      else $error("torque reference not zero with loop on");

endmodule // mrc_realtime_regs

// *** verification/test_motor_realtime_control_regs.sv ***
`timescale 1ns/1ps
module test_motor_realtime_control_regs
   import mrc_pkg::*;
;
   // clock and reset
   logic                clock = 1'b0;
   logic                nrst = 1'b0;
   // register access request
   mrc_bus_req_t        bus_req = '0;
   // controller context
   mrc_startup_t        startup_method = start_other;
   logic                speed_detect_enable = 1'b0;
   logic                velocity_loop_off = 1'b0;
   logic [8:0]          preset_align_angle = 9'h000;
   // design outputs
   logic [31:0]         rdata_ff;
   logic                rvalid_ff;
   logic                addr_err_ff;
   logic [14:0]         motion_target_ff;
   logic                fault_clear_ff;
   logic [8:0]          align_angle_ff;
   logic                open_loop_select_ff;
   mrc_hold_t           hold_ff;
   logic signed [10:0]  torque_current_reference_ff;
   logic                torque_override_active_ff;
   logic                torque_code_invalid_ff;
   // bookkeeping
   int                  n_mismatch = 0;
   int                  num_checks = 0;
   logic [3:0]          hexp;
   // angle and torque codes, chosen at the fold and sign boundaries
   int                  angs[4] = '{0, 359, 360, 511};
   int                  codes[6] = '{0, 511, 512, 513, 1000, 1023};

   // 200 MHz clock
   always #2.5 clock = ~clock;

   mrc_realtime_regs i_mrc_realtime_regs (
      .clock                       (clock),
      .nrst                        (nrst),
      .bus_req                     (bus_req),
      .rdata_ff                    (rdata_ff),
      .rvalid_ff                   (rvalid_ff),
      .addr_err_ff                 (addr_err_ff),
      .startup_method              (startup_method),
      .speed_detect_enable         (speed_detect_enable),
      .velocity_loop_off           (velocity_loop_off),
      .preset_align_angle          (preset_align_angle),
      .motion_target_ff            (motion_target_ff),
      .fault_clear_ff              (fault_clear_ff),
      .align_angle_ff              (align_angle_ff),
      .open_loop_select_ff         (open_loop_select_ff),
      .hold_ff                     (hold_ff),
      .torque_current_reference_ff (torque_current_reference_ff),
      .torque_override_active_ff   (torque_override_active_ff),
      .torque_code_invalid_ff      (torque_code_invalid_ff)
   );

   // verdict and end of run, shared with the watchdog
   task summarize;
      if (n_mismatch == 0 && num_checks > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask

   // compare a read word
   task chk_rd(input logic [31:0] got, input logic [31:0] exp);
      num_checks++;
      if (got !== exp) begin
         n_mismatch++;
         $display("MISMATCH %0t read %h expected %h", $time, got, exp);
      end
   endtask

   // compare a control output, zero extended
   task chk_out(input logic [31:0] got, input logic [31:0] exp,
                input string what);
      num_checks++;
      if (got !== exp) begin
         n_mismatch++;
         $display("MISMATCH %0t %s %h expected %h", $time, what, got, exp);
      end
   endtask

   // one-cycle write strobe; the register takes it at the second edge
   task wr_reg(input logic [7:0] a, input logic [31:0] d);
      @(posedge clock);
      bus_req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
      @(posedge clock);
      bus_req.wr <= 1'b0;
   endtask

   // one-cycle read strobe; answer is looked at one cycle later
   task rd_reg(input logic [7:0] a, input logic [31:0] e);
      @(posedge clock);
      bus_req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 32'h0000_0000};
      @(posedge clock);
      bus_req.rd <= 1'b0;
      #1;
      chk_out({31'h0, rvalid_ff}, 32'h0000_0001, "rvalid");
      chk_rd(rdata_ff, e);
   endtask

   // derived outputs trail the register by one more edge
   task settle;
      repeat (2) @(posedge clock);
      #1;
   endtask

   // main sequence
   initial begin
      repeat (3) @(posedge clock);
      nrst <= 1'b1;
      // both words start at zero
      rd_reg(MOTION_TARGET_OFS, 32'h0000_0000);
      rd_reg(STARTUP_OVERRIDE_OFS, 32'h0000_0000);
      // speed target keeps only its low 15 bits
      wr_reg(MOTION_TARGET_OFS, 32'hffff_ffff);
      rd_reg(MOTION_TARGET_OFS, 32'h0000_7fff);
      chk_out({17'h0, motion_target_ff}, 32'h0000_7fff, "target");
      wr_reg(MOTION_TARGET_OFS, 32'h0000_4321);
      settle;
      chk_out({17'h0, motion_target_ff}, 32'h0000_4321, "target");
      // all ones: fault clear pulses once, reserved bits stay zero
      wr_reg(STARTUP_OVERRIDE_OFS, 32'hffff_ffff);
      #1;
      chk_out({31'h0, fault_clear_ff}, 32'h0000_0001, "fault");
      @(posedge clock);
      #1;
      chk_out({31'h0, fault_clear_ff}, 32'h0000_0000, "fault");
      rd_reg(STARTUP_OVERRIDE_OFS, 32'h7fc0_ffff);
      chk_out({31'h0, open_loop_select_ff}, 32'h0000_0001, "open");
      // unmapped address is flagged and changes nothing
      wr_reg(8'h08, 32'h0000_0000);
      #1;
      chk_out({31'h0, addr_err_ff}, 32'h0000_0001, "addr_err");
      rd_reg(8'h08, 32'h0000_0000);
      chk_out({31'h0, addr_err_ff}, 32'h0000_0001, "addr_err");
      rd_reg(STARTUP_OVERRIDE_OFS, 32'h7fc0_ffff);
      wr_reg(STARTUP_OVERRIDE_OFS, 32'h0000_0000);
      settle;
      chk_out({31'h0, open_loop_select_ff}, 32'h0000_0000, "open");
      // hold bits only bite when the method matches, speed detect hold when speed detect is enabled
      for (int m = 0; m < 5; m++) begin
         for (int s = 0; s < 2; s++) begin
            @(posedge clock);
            startup_method <= mrc_startup_t'(m);
            speed_detect_enable <= s[0];
            wr_reg(STARTUP_OVERRIDE_OFS, 32'h0000_7800);
            settle;
            hexp = {m < 2, m == 2, m == 3, s == 1};
            chk_out({28'h0, hold_ff}, 32'(hexp), "hold");
            wr_reg(STARTUP_OVERRIDE_OFS, 32'h0000_0000);
            settle;
            chk_out({28'h0, hold_ff}, 32'h0, "hold");
         end
      end
      // register angle folded modulo 360
      foreach (angs[i]) begin
         wr_reg(STARTUP_OVERRIDE_OFS,
                (32'(angs[i]) << 22) | 32'h0000_0400);
         settle;
         chk_out({23'h0, align_angle_ff},
                 32'(angs[i] % 360), "angle");
      end
      // preset angle wins when the source bit is clear
      @(posedge clock);
      preset_align_angle <= 9'h190;
      wr_reg(STARTUP_OVERRIDE_OFS, 32'h7fc0_0000);
      settle;
      chk_out({23'h0, align_angle_ff}, 32'h0000_0028, "angle");
      // torque code sign split at 512, flag past 1000
      @(posedge clock);
      velocity_loop_off <= 1'b1;
      foreach (codes[i]) begin
         wr_reg(STARTUP_OVERRIDE_OFS, 32'(codes[i]));
         settle;
         chk_out({21'h0, torque_current_reference_ff},
                 {21'h0, 11'(codes[i] < 512 ? codes[i] : 512 - codes[i])},
                 "torque");
         chk_out({31'h0, torque_code_invalid_ff}, 32'(codes[i] > 1000),
                 "invalid");
         chk_out({31'h0, torque_override_active_ff}, 32'h0000_0001,
                 "active");
      end
      // reference drops out once the velocity loop runs again
      @(posedge clock);
      velocity_loop_off <= 1'b0;
      settle;
      chk_out({21'h0, torque_current_reference_ff}, 32'h0000_0000,
              "torque");
      chk_out({31'h0, torque_override_active_ff}, 32'h0000_0000,
              "active");
      // a mid-run reset must wipe words that software has written
      wr_reg(MOTION_TARGET_OFS, 32'h0000_1234);
      @(posedge clock);
      nrst <= 1'b0;
      repeat (3) @(posedge clock);
      nrst <= 1'b1;
      rd_reg(MOTION_TARGET_OFS, 32'h0000_0000);
      rd_reg(STARTUP_OVERRIDE_OFS, 32'h0000_0000);
      chk_out({17'h0, motion_target_ff}, 32'h0000_0000, "target");
      summarize;
   end

   // watchdog: the sequence needs well under a thousand cycles
   initial begin
      repeat (4000) @(posedge clock);
      n_mismatch++;
      summarize;
   end

endmodule // test_motor_realtime_control_regs
